// [rtl/dtpb_timer.sv]
// up timer, down timer with pwm and buzzer, and the shared pin mux
// assumes a one-cycle instruction tick and write strobes on i_clock;
// the external clock pin and low-speed oscillator are asynchronous
`timescale 1ns/1ps
`default_nettype none

module dtpb_timer (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_inst_tick,
   input wire logic i_external_clock_in,
   input wire logic i_low_speed_rc_osc,
   input wire logic i_async_mode,
   input wire logic i_global_irq_enable,
   input wire logic i_up_timer_run,
   input wire logic i_up_timer_source_sel,
   input wire logic i_up_timer_lowclk_sel,
   input wire logic i_up_timer_edge_sel,
   input wire logic i_shared_prescaler_assign,
   input wire logic [2:0] i_shared_prescaler_rate,
   input wire logic i_up_timer_mode_wr,
   input wire logic i_up_timer_wr,
   input wire logic [7:0] i_up_timer_wdata,
   input wire logic i_up_timer_overflow_irq_en,
   input wire logic i_up_timer_overflow_clear,
   input wire logic i_down_timer_run,
   input wire logic i_down_timer_source_sel,
   input wire logic i_down_timer_edge_sel,
   input wire logic i_down_prescaler_enable_n,
   input wire logic [2:0] i_down_prescaler_rate,
   input wire logic i_down_timer_one_shot,
   input wire logic i_down_timer_reload_sel,
   input wire logic i_down_timer_wr,
   input wire logic [7:0] i_down_timer_wdata,
   input wire logic i_down_timer_underflow_irq_en,
   input wire logic i_down_timer_underflow_clear,
   input wire logic i_pwm_output_enable,
   input wire logic i_pwm_active_low,
   input wire logic [7:0] i_pwm_duty_value,
   input wire logic i_buzzer_enable,
   input wire logic [3:0] i_buzzer_freq_sel,
   input wire logic i_pin_cfg_pwm,
   input wire logic i_pin_cfg_buzzer,
   output logic [7:0] o_up_timer_value,
   output logic o_up_timer_overflow_flag,
   output logic o_up_timer_irq,
   output logic [7:0] o_shared_prescaler_count,
   output logic [7:0] o_down_timer_value,
   output logic [7:0] o_down_timer_reload,
   output logic [7:0] o_down_prescaler_count,
   output logic o_down_timer_underflow_flag,
   output logic o_down_timer_irq,
   output logic o_down_timer_stopped,
   output logic o_pin_out,
   output logic o_pin_oe
);
   // synchronisers and edge history
   logic ext_meta_q;
   logic ext_sync_q;
   logic ext_prev_q;
   logic lrc_meta_q;
   logic lrc_sync_q;
   logic lrc_prev_q;
   // counters and state
   logic [7:0] up_q;
   logic [7:0] up_d;
   logic up_pend_q;
   logic up_pend_d;
   logic up_flag_q;
   logic [7:0] down_q;
   logic [7:0] down_d;
   logic [7:0] reload_q;
   logic stopped_q;
   logic stopped_d;
   logic down_flag_q;
   logic pin_out_q;
   logic pin_oe_q;

   // pick the up timer's slow source and its active edge
   logic src_now;
   logic src_prev;
   logic src_edge;
   logic ext_rise;
   logic ext_fall;
   assign src_now = i_up_timer_lowclk_sel ? lrc_sync_q : ext_sync_q;
   assign src_prev = i_up_timer_lowclk_sel ? lrc_prev_q : ext_prev_q;
   assign src_edge = i_up_timer_edge_sel ? (src_prev && !src_now)
                                         : (!src_prev && src_now);
   assign ext_rise = !ext_prev_q && ext_sync_q;
   assign ext_fall = ext_prev_q && !ext_sync_q;

   // instruction-clock alignment of slow edges unless async is chosen
   logic up_src_tick;
   logic up_in_tick;
   logic up_pre_out;
   logic up_adv;
   logic up_ovf;
   logic presc_clear;
   assign up_src_tick = i_async_mode ? src_edge
                        : ((up_pend_q || src_edge) && i_inst_tick);
   assign up_pend_d = i_up_timer_source_sel && !i_async_mode &&
                      !i_inst_tick && (up_pend_q || src_edge);
   assign up_in_tick = i_up_timer_run &&
      (i_up_timer_source_sel ? up_src_tick : i_inst_tick);
   assign presc_clear = i_up_timer_mode_wr &&
                        !i_shared_prescaler_assign;
   assign up_adv = i_shared_prescaler_assign ? up_in_tick
                                             : up_pre_out;
   assign up_ovf = up_adv && (up_q == dtpb_pkg::DTPB_COUNT_MAX) &&
                   !i_up_timer_wr;
   assign up_d = i_up_timer_wr ? i_up_timer_wdata : up_q + 8'h01;

   // shared prescaler, fed only while it serves the up timer
   dtpb_prescaler #(
      .WIDTH(dtpb_pkg::DTPB_WIDTH)
   ) u_shared_presc (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_tick(up_in_tick && !i_shared_prescaler_assign),
      .i_clear(presc_clear),
      .i_rate(i_shared_prescaler_rate),
      .o_tick(up_pre_out),
      .o_count(o_shared_prescaler_count)
   );

   // down timer source, prescaler and next count
   logic down_in_tick;
   logic down_pre_out;
   logic down_adv;
   logic down_unf;
   logic [7:0] restart_value;
   assign down_in_tick = i_down_timer_run && !stopped_q &&
      (i_down_timer_source_sel
         ? (i_down_timer_edge_sel ? ext_fall : ext_rise)
         : i_inst_tick);
   assign down_adv = i_down_prescaler_enable_n ? down_in_tick
                                               : down_pre_out;
   assign down_unf = down_adv && !i_down_timer_wr &&
                     (down_q <= dtpb_pkg::DTPB_COUNT_ONE);
   assign restart_value = i_down_timer_reload_sel ? reload_q
                          : dtpb_pkg::DTPB_COUNT_MAX;

   // next down count: write, one-shot end, restart or decrement
   always_comb begin
      down_d = down_q;
      stopped_d = stopped_q;
      if (i_down_timer_wr) begin
         down_d = i_down_timer_wdata;
         stopped_d = 1'b0;
      end else if (down_unf && i_down_timer_one_shot) begin
         down_d = dtpb_pkg::DTPB_COUNT_ZERO;
         stopped_d = 1'b1;
      end else if (down_unf) begin
         down_d = restart_value;
      end else if (down_adv) begin
         down_d = down_q - 8'h01;
      end
   end

   // down prescaler, also the buzzer's prescaler source
   dtpb_prescaler #(
      .WIDTH(dtpb_pkg::DTPB_WIDTH)
   ) u_down_presc (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_tick(down_in_tick),
      .i_clear(i_down_timer_wr),
      .i_rate(i_down_prescaler_rate),
      .o_tick(down_pre_out),
      .o_count(o_down_prescaler_count)
   );

   // pwm level and buzzer bit selection
   logic pwm_active;
   logic pwm_level;
   logic bz_bit;
   logic bz_level;
   logic pwm_sel;
   logic bz_sel;
   assign pwm_active = i_down_timer_run &&
      (down_q != dtpb_pkg::DTPB_COUNT_ZERO) &&
      (down_q <= i_pwm_duty_value);
   assign pwm_level = pwm_active ^ i_pwm_active_low;
   assign bz_bit = i_buzzer_freq_sel[dtpb_pkg::DTPB_BZ_SRC_BIT]
      ? down_q[i_buzzer_freq_sel[2:0]]
      : o_down_prescaler_count[i_buzzer_freq_sel[2:0]];
   assign bz_level = i_down_timer_run && bz_bit;
   assign pwm_sel = i_pwm_output_enable && i_pin_cfg_pwm;
   assign bz_sel = i_buzzer_enable && i_pin_cfg_buzzer;

   // two-stage synchronisers plus edge history
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
         lrc_meta_q <= 1'b0;
         lrc_sync_q <= 1'b0;
         lrc_prev_q <= 1'b0;
      end else if (i_ce) begin
         ext_meta_q <= i_external_clock_in;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
         lrc_meta_q <= i_low_speed_rc_osc;
         lrc_sync_q <= lrc_meta_q;
         lrc_prev_q <= lrc_sync_q;
      end
   end

   // up timer count and pending slow edge
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         up_q <= dtpb_pkg::DTPB_COUNT_RESET;
         up_pend_q <= 1'b0;
      end else if (i_ce) begin
         up_pend_q <= up_pend_d;
         if (i_up_timer_wr || up_adv) begin
            up_q <= up_d;
         end
      end
   end

   // down timer count, reload and one-shot stop
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         down_q <= dtpb_pkg::DTPB_COUNT_RESET;
         reload_q <= dtpb_pkg::DTPB_RELOAD_RESET;
         stopped_q <= 1'b0;
      end else if (i_ce) begin
         down_q <= down_d;
         stopped_q <= stopped_d;
         if (i_down_timer_wr) begin
            reload_q <= i_down_timer_wdata;
         end
      end
   end

   // sticky flags: a new event wins over a clear in the same cycle
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         up_flag_q <= 1'b0;
         down_flag_q <= 1'b0;
      end else if (i_ce) begin
         up_flag_q <= up_ovf ||
                      (up_flag_q && !i_up_timer_overflow_clear);
         down_flag_q <= down_unf ||
                        (down_flag_q && !i_down_timer_underflow_clear);
      end
   end

   // shared pin: pwm first, then buzzer, else released
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         pin_out_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end else if (i_ce) begin
         pin_oe_q <= pwm_sel || bz_sel;
         pin_out_q <= pwm_sel ? pwm_level : (bz_sel && bz_level);
      end
   end

   // outputs
   assign o_up_timer_value = up_q;
   assign o_up_timer_overflow_flag = up_flag_q;
   assign o_up_timer_irq = up_flag_q && i_up_timer_overflow_irq_en &&
                           i_global_irq_enable;
   assign o_down_timer_value = down_q;
   assign o_down_timer_reload = reload_q;
   assign o_down_timer_underflow_flag = down_flag_q;
   assign o_down_timer_irq = down_flag_q && i_down_timer_underflow_irq_en &&
                             i_global_irq_enable;
   assign o_down_timer_stopped = stopped_q;
   assign o_pin_out = pin_out_q;
   assign o_pin_oe = pin_oe_q;

   // checks
   default clocking dtpb_cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   a_up_write_load: assert property (
      i_ce && i_up_timer_wr |=> up_q == $past(i_up_timer_wdata))
      else $error("up timer write not loaded");
   a_up_hold_stop: assert property (
      i_ce && !i_up_timer_run && !i_up_timer_wr |=> $stable(up_q))
      else $error("up timer moved while stopped");
   a_up_ovf_flag: assert property (
      i_ce && up_adv && up_q == 8'hff && !i_up_timer_wr
      |=> up_flag_q && up_q == 8'h00)
      else $error("overflow did not set flag");
   a_down_reload_val: assert property (
      i_ce && down_unf && !i_down_timer_one_shot && i_down_timer_reload_sel
      |=> down_q == $past(reload_q))
      else $error("continuous restart not from reload");
   a_down_restart_ff: assert property (
      i_ce && down_unf && !i_down_timer_one_shot && !i_down_timer_reload_sel
      |=> down_q == 8'hff)
      else $error("continuous restart not from 0xff");
   a_one_shot_stop: assert property (
      i_ce && down_unf && i_down_timer_one_shot
      |=> stopped_q && down_q == 8'h00 ##1 (down_q == 8'h00 ||
          $past(i_down_timer_wr)))
      else $error("one-shot did not stop at zero");
   a_flag_set_wins: assert property (
      i_ce && down_unf && i_down_timer_underflow_clear |=> down_flag_q)
      else $error("underflow lost against clear");
   a_pwm_duty_zero: assert property (
      i_ce && pwm_sel && i_pwm_duty_value == 8'h00
      |=> o_pin_oe && o_pin_out == $past(i_pwm_active_low))
      else $error("zero duty drove pwm active");
   a_down_write_both: assert property (
      i_ce && i_down_timer_wr |=> down_q == $past(i_down_timer_wdata) &&
      reload_q == $past(i_down_timer_wdata))
      else $error("down write missed reload or count");
   a_up_count_step: assert property (
      i_ce && up_adv && !i_up_timer_wr
      |=> up_q == $past(up_q) + 8'h01)
      else $error("up timer did not increment");
   a_down_flag_set: assert property (
      i_ce && down_unf |=> down_flag_q)
      else $error("underflow did not set flag");
   a_up_flag_sticky: assert property (
      i_ce && up_flag_q && !i_up_timer_overflow_clear |=> up_flag_q)
      else $error("overflow flag dropped without clear");
   a_down_hold_stop: assert property (
      i_ce && !i_down_timer_run && !i_down_timer_wr |=> $stable(down_q))
      else $error("down timer moved while stopped");
   a_one_shot_hold: assert property (
      i_ce && stopped_q && !i_down_timer_wr |=> $stable(down_q))
      else $error("one-shot counted after stop");
   a_down_count_step: assert property (
      i_ce && down_adv && !i_down_timer_wr && !down_unf
      |=> down_q == $past(down_q) - 8'h01)
      else $error("down timer did not decrement");
   a_presc_clear: assert property (
      i_ce && presc_clear |=> o_shared_prescaler_count == 8'h00)
      else $error("prescaler not cleared by assignment write");
   a_pin_release: assert property (
      i_ce && !pwm_sel && !bz_sel |=> !o_pin_oe)
      else $error("pin driven with no function selected");
   a_bz_stop_low: assert property (
      i_ce && bz_sel && !pwm_sel && !i_down_timer_run |=> !o_pin_out)
      else $error("buzzer toggled while timer stopped");

   c_up_overflow: cover property (i_ce && up_ovf);
   c_down_continuous: cover property (
      i_ce && down_unf && !i_down_timer_one_shot ##[1:300] i_ce && down_unf);
   c_one_shot_done: cover property (i_ce && down_unf && i_down_timer_one_shot);
   c_buzzer_pin: cover property (bz_sel && !pwm_sel && o_pin_out);
   c_pwm_active: cover property (pwm_sel && pwm_active);
endmodule : dtpb_timer

`default_nettype wire

// [rtl/dtpb_pkg.sv]
// constants shared by the dual timer, its prescalers and the pin mux
// assumes one 20 MHz clock and an instruction-clock tick from the core
//
// What this block does
// - up timer counts up while run set
// - write loads start count, read gives count
// - source and low-clock bits pick up clock
// - edge bit picks falling or rising source edge
// - assign zero: prescaler divides; zero write clears
// - shared rate field divides 1:2 to 1:256
// - sync to instruction clock unless async option
// - overflow sets sticky flag; irq when enabled
// - down timer write sets reload and count
// - down run bit; source bit picks pin
// - down edge bit picks falling or rising
// - active-low enable; rate field 1:2 to 1:256
// - down prescaler count readable by software
// - one-shot counts to zero then stops
// - continuous restarts from reload or 0xff
// - underflow sets sticky flag; irq when enabled
// - pwm enable and pin config drive pin
// - polarity bit makes pwm active low
// - duty zero never active; period is reload with reload select, else 0xff
// - buzzer picks prescaler or timer bit

package dtpb_pkg;
   localparam int unsigned DTPB_WIDTH = 8;
   localparam int unsigned DTPB_RATE_W = 3;
   localparam int unsigned DTPB_BZ_W = 4;
   localparam logic [7:0] DTPB_COUNT_RESET = 8'h00;
   localparam logic [7:0] DTPB_COUNT_MAX = 8'hff;
   localparam logic [7:0] DTPB_COUNT_ONE = 8'h01;
   localparam logic [7:0] DTPB_COUNT_ZERO = 8'h00;
   localparam logic [7:0] DTPB_RELOAD_RESET = 8'h00;
   localparam logic [7:0] DTPB_DUTY_RESET = 8'h00;
   // buzzer select: top bit picks source, low bits pick counter bit
   localparam int unsigned DTPB_BZ_SRC_BIT = 3;
   localparam logic [2:0] DTPB_RATE_TOP = 3'h7;
   localparam logic [7:0] DTPB_FULL_MASK = 8'hff;
   // clock rate and period
   localparam int unsigned DTPB_CLOCK_HZ = 20000000;
   localparam int unsigned DTPB_CLOCK_PERIOD_NS = 50;
endpackage : dtpb_pkg

// [rtl/dtpb_prescaler.sv]
// ripple-free power-of-two prescaler with a readable count
// assumes i_tick is a one-cycle pulse in the i_clock domain
`timescale 1ns/1ps
`default_nettype none

module dtpb_prescaler #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_tick,
   input wire logic i_clear,
   input wire logic [2:0] i_rate,
   output logic o_tick,
   output logic [WIDTH-1:0] o_count
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   logic [WIDTH-1:0] rate_mask;

   // mask of low bits that must all be one for a terminal tick
   assign rate_mask = WIDTH'(dtpb_pkg::DTPB_FULL_MASK >>
                      (dtpb_pkg::DTPB_RATE_TOP - i_rate));
   assign o_tick = i_tick && ((count_q & rate_mask) == rate_mask);
   assign count_d = count_q + WIDTH'(1);
   assign o_count = count_q;

   // count input ticks; clear wins over a tick
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         count_q <= '0;
      end else if (i_ce) begin
         if (i_clear) begin
            count_q <= '0;
         end else if (i_tick) begin
            count_q <= count_d;
         end
      end
   end
endmodule : dtpb_prescaler

`default_nettype wire

// [verif/dtpb_pin_partner.sv]
// pin partner: drives the external clock pin and resolves the shared pin
// assumes one clock; the pin floats to a pull-up when nobody drives it
`timescale 1ns/1ps
`default_nettype none

module dtpb_pin_partner (
   input wire logic i_clock,
   input wire logic i_start,
   input wire logic [7:0] i_edges,
   input wire logic i_pin_out,
   input wire logic i_pin_oe,
   output logic o_ext_clk,
   output logic o_busy,
   output logic o_pin_level
);
   logic [8:0] left_q = 9'h000;
   logic [1:0] div_q = 2'h0;
   logic clk_q = 1'b0;
   // bursts of rising edges, one every 8 cycles; rests low between bursts
   always @(posedge i_clock) begin
      if (i_start) begin
         left_q <= {i_edges, 1'b0};
         div_q <= 2'h0;
      end else if (left_q != 9'h000) begin
         div_q <= div_q + 2'h1;
         if (div_q == 2'h3) begin
            left_q <= left_q - 9'h001;
            clk_q <= ~clk_q;
         end
      end
   end
   assign o_ext_clk = clk_q;
   assign o_busy = (left_q != 9'h000);
   // released pin goes to the pull-up level
   assign o_pin_level = i_pin_oe ? i_pin_out : 1'b1;
endmodule : dtpb_pin_partner

`default_nettype wire

// [verif/dtpb_timer_test.sv]
// self-checking bench for the dual timer, pwm and buzzer pin
// assumes the design files and the pin partner are compiled first
`timescale 1ns/1ps
`default_nettype none

module dtpb_timer_test;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic tick = 1'b0, tick_en = 1'b1, lrc, asy, global_irq_enable, p_start;
   logic u_run, u_src, u_low, u_edge, u_asg, u_mwr, u_wr, u_ie, u_clr;
   logic d_run, d_src, d_edge, d_pen_n, d_os, d_rl, d_wr, d_ie, d_clr;
   logic p_en, p_al, b_en, cfg_p, cfg_b, u_flag, u_irq, d_flag, d_irq;
   logic d_stop, pin_o, pin_oe, ext_clk, p_busy, pin_lvl;
   logic [2:0] u_rate, d_rate;
   logic [3:0] b_sel;
   logic [7:0] u_wd, d_wd, duty, p_edges, u_val, sp_cnt, d_val, d_rld, dp_cnt;
   logic [7:0] c;
   logic [1:0] tcnt = 2'h0;
   logic ce = 1'b1;
   int n_mismatch = 0;
   int tests_run = 0;
   int cyc = 0;

   dtpb_timer u_dtpb_timer (.i_clock(i_clock), .i_reset(i_reset),
      .i_ce(ce), .i_inst_tick(tick), .i_external_clock_in(ext_clk),
      .i_low_speed_rc_osc(lrc), .i_async_mode(asy),
      .i_global_irq_enable(global_irq_enable), .i_up_timer_run(u_run),
      .i_up_timer_source_sel(u_src), .i_up_timer_lowclk_sel(u_low),
      .i_up_timer_edge_sel(u_edge), .i_shared_prescaler_assign(u_asg),
      .i_shared_prescaler_rate(u_rate), .i_up_timer_mode_wr(u_mwr),
      .i_up_timer_wr(u_wr), .i_up_timer_wdata(u_wd),
      .i_up_timer_overflow_irq_en(u_ie), .i_up_timer_overflow_clear(u_clr),
      .i_down_timer_run(d_run), .i_down_timer_source_sel(d_src),
      .i_down_timer_edge_sel(d_edge), .i_down_prescaler_enable_n(d_pen_n),
      .i_down_prescaler_rate(d_rate), .i_down_timer_one_shot(d_os),
      .i_down_timer_reload_sel(d_rl), .i_down_timer_wr(d_wr),
      .i_down_timer_wdata(d_wd), .i_down_timer_underflow_irq_en(d_ie),
      .i_down_timer_underflow_clear(d_clr), .i_pwm_output_enable(p_en),
      .i_pwm_active_low(p_al), .i_pwm_duty_value(duty),
      .i_buzzer_enable(b_en), .i_buzzer_freq_sel(b_sel),
      .i_pin_cfg_pwm(cfg_p), .i_pin_cfg_buzzer(cfg_b),
      .o_up_timer_value(u_val), .o_up_timer_overflow_flag(u_flag),
      .o_up_timer_irq(u_irq), .o_shared_prescaler_count(sp_cnt),
      .o_down_timer_value(d_val), .o_down_timer_reload(d_rld),
      .o_down_prescaler_count(dp_cnt), .o_down_timer_underflow_flag(d_flag),
      .o_down_timer_irq(d_irq), .o_down_timer_stopped(d_stop),
      .o_pin_out(pin_o), .o_pin_oe(pin_oe));

   dtpb_pin_partner u_dtpb_pin_partner (.i_clock(i_clock),
      .i_start(p_start), .i_edges(p_edges), .i_pin_out(pin_o),
      .i_pin_oe(pin_oe), .o_ext_clk(ext_clk), .o_busy(p_busy),
      .o_pin_level(pin_lvl));

   // clock, instruction tick every 4 cycles, run-time ceiling
   always #25 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      tcnt <= tcnt + 2'h1;
      tick <= tick_en && (tcnt == 2'h3);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude;
      end
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk8

   // strobe write aligned just after a tick: bit0 up, bit1 mode, bit2 down
   task automatic wr(input logic [2:0] w, input logic [7:0] v);
      do @(posedge i_clock); while (tick !== 1'b1);
      {d_wr, u_mwr, u_wr} <= w;
      u_wd <= v;
      d_wd <= v;
      @(posedge i_clock);
      {d_wr, u_mwr, u_wr} <= 3'h0;
      #1;
   endtask : wr

   task automatic step(input int n);
      repeat (4 * n) @(posedge i_clock);
      #1;
   endtask : step

   task automatic ext(input logic [7:0] n);
      @(posedge i_clock);
      p_edges <= n;
      p_start <= 1'b1;
      @(posedge i_clock);
      p_start <= 1'b0;
      @(posedge i_clock);
      while (p_busy) @(posedge i_clock);
      repeat (12) @(posedge i_clock);
      #1;
   endtask : ext

   task automatic highs;
      c = 8'h00;
      repeat (64) begin
         @(posedge i_clock);
         #1;
         c += {7'h0, pin_lvl};
      end
   endtask : highs

   initial begin
      {lrc, asy, global_irq_enable, p_start, u_run, u_src, u_low, u_edge, u_mwr} = '0;
      {u_wr, u_ie, u_clr, d_run, d_src, d_edge, d_os, d_rl, d_wr} = '0;
      {d_ie, d_clr, p_en, p_al, b_en, cfg_p, cfg_b, u_rate, d_rate} = '0;
      {b_sel, u_wd, d_wd, duty, p_edges} = '0;
      u_asg = 1'b1;
      d_pen_n = 1'b1;
      repeat (3) @(posedge i_clock);
      i_reset <= 1'b0;
      @(posedge i_clock);
      u_run <= 1'b1;
      u_ie <= 1'b1;
      global_irq_enable <= 1'b1;
      wr(3'h1, 8'hfe);
      chk8(u_val, 8'hfe);
      step(1);
      chk8(u_val, 8'hff);
      step(1);
      chk8(u_val, 8'h00);
      chk8({6'h0, u_irq, u_flag}, 8'h03);
      @(posedge i_clock);
      global_irq_enable <= 1'b0;
      u_clr <= 1'b1;
      u_run <= 1'b0;
      @(posedge i_clock);
      u_clr <= 1'b0;
      wr(3'h1, 8'hff);
      step(3);
      chk8({u_val[6:0], u_flag}, 8'hfe);
      $display("up timer count test done");
      for (int r = 0; r < 8; r++) begin
         @(posedge i_clock);
         u_asg <= 1'b0;
         u_rate <= r[2:0];
         u_run <= 1'b1;
         wr(3'h3, 8'h00);
         chk8(sp_cnt, 8'h00);
         step(3 << (r + 1));
         chk8(u_val, 8'h03);
      end
      $display("prescaler test done");
      @(posedge i_clock);
      u_asg <= 1'b1;
      u_src <= 1'b1;
      for (int e = 0; e < 2; e++) begin
         @(posedge i_clock);
         u_edge <= e[0];
         repeat (8) @(posedge i_clock);
         wr(3'h1, 8'h10);
         ext(8'h05);
         chk8(u_val, 8'h15);
      end
      @(posedge i_clock);
      u_low <= 1'b1; // slow clock is not the tick
      wr(3'h1, 8'h20);
      repeat (8) begin
         repeat (4) @(posedge i_clock);
         lrc <= ~lrc;
      end
      repeat (12) @(posedge i_clock);
      #1;
      chk8(u_val, 8'h24);
      @(posedge i_clock);
      u_low <= 1'b0;
      wr(3'h1, 8'h30);
      tick_en <= 1'b0;
      asy <= 1'b1;
      ext(8'h03);
      chk8(u_val, 8'h33);
      asy <= 1'b0;
      ext(8'h03);
      chk8(u_val, 8'h33);
      tick_en <= 1'b1;
      u_run <= 1'b0;
      $display("up timer source test done");
      @(posedge i_clock);
      d_rl <= 1'b1;
      d_ie <= 1'b1;
      global_irq_enable <= 1'b1;
      wr(3'h4, 8'h03);
      d_run <= 1'b1;
      chk8(d_rld, 8'h03);
      step(1);
      chk8(d_val, 8'h02);
      step(2);
      chk8(d_val, 8'h03);
      chk8({6'h0, d_irq, d_flag}, 8'h03);
      @(posedge i_clock);
      d_rl <= 1'b0;
      d_clr <= 1'b1;
      @(posedge i_clock);
      d_clr <= 1'b0;
      step(3);
      chk8({d_val[6:0], d_flag}, 8'hff);
      @(posedge i_clock);
      d_os <= 1'b1;
      wr(3'h4, 8'h02);
      step(4);
      chk8({d_val[6:0], d_stop}, 8'h01);
      @(posedge i_clock);
      d_os <= 1'b0;
      d_pen_n <= 1'b0;
      wr(3'h4, 8'h10);
      step(4);
      chk8(d_val, 8'h0e);
      chk8(dp_cnt, 8'h04);
      ce <= 1'b0;
      step(2);
      chk8({dp_cnt[3:0], d_val[3:0]}, 8'h4e);
      ce <= 1'b1;
      @(posedge i_clock);
      d_pen_n <= 1'b1;
      d_src <= 1'b1;
      for (int e = 0; e < 2; e++) begin
         @(posedge i_clock);
         d_edge <= e[0];
         repeat (8) @(posedge i_clock);
         wr(3'h4, 8'h10);
         ext(8'h03);
         chk8(d_val, 8'h0d);
      end
      @(posedge i_clock);
      d_src <= 1'b0;
      d_run <= 1'b0;
      wr(3'h4, 8'h05);
      step(3);
      chk8(d_val, 8'h05);
      $display("down timer test done");
      @(posedge i_clock);
      d_run <= 1'b1;
      d_rl <= 1'b1;
      p_en <= 1'b1;
      cfg_p <= 1'b1;
      wr(3'h4, 8'h04);
      for (int k = 0; k < 4; k++) begin
         @(posedge i_clock);
         duty <= k[0] ? 8'h01 : 8'h00;
         p_al <= k[1];
         d_clr <= (k == 0); // underflow against a held clear
         step(4);
         highs;
         chk8(c, k[1] ? 8'h40 - {3'h0, k[0], 4'h0} : {3'h0, k[0], 4'h0});
         chk8({7'h0, pin_oe}, 8'h01);
      end
      @(posedge i_clock);
      p_en <= 1'b0;
      step(1);
      chk8({6'h0, pin_oe, pin_lvl}, 8'h01);
      @(posedge i_clock);
      b_en <= 1'b1;
      cfg_b <= 1'b1;
      b_sel <= 4'h8;
      step(4);
      highs;
      chk8(c, 8'h20);
      @(posedge i_clock);
      b_sel <= 4'h0;
      step(1);
      highs;
      chk8(c, 8'h20);
      @(posedge i_clock);
      d_run <= 1'b0;
      step(2);
      chk8({6'h0, pin_oe, pin_lvl}, 8'h02);
      $display("pin output test done");
      conclude;
   end
endmodule : dtpb_timer_test

`default_nettype wire
